// file: rtl/dia_cfg.svh
`ifndef DIA_CFG_SVH
`define DIA_CFG_SVH
`define DIA_OFS_CTRL   8'h00
`define DIA_OFS_THR0   8'h04
`define DIA_OFS_THR1   8'h08
`define DIA_OFS_CNT0   8'h0C
`define DIA_OFS_CNT1   8'h10
`define DIA_OFS_STAT   8'h14
`define DIA_OFS_IRQST  8'h18
`define DIA_OFS_IRQMSK 8'h1C
`define DIA_OFS_CLR    8'h20
`define DIA_CTRL_EN    0
`define DIA_CTRL_MODE  1
`define DIA_CTRL_INV   2
`define DIA_CTRL_STRIDE 4
`define DIA_RST_CTRL   8'h00
`define DIA_RST_THR    16'h0000
`define DIA_RST_MASK   4'h0
`endif

// file: rtl/dia_pkg.sv
package dia_pkg;
  typedef enum logic {DIA_LEVEL, DIA_COUNT} dia_mode_t;
endpackage : dia_pkg

// file: rtl/dia_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "dia_cfg.svh"
module dia_channel
  import dia_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  input  wire logic          senseIn,
  input  wire logic          enable,
  input  wire dia_mode_t     mode,
  input  wire logic          invert,
  input  wire logic [15:0]   threshold,
  input  wire logic          clearCount,
  input  wire logic          rearm,
  output logic               alarm,
  output logic [CW-1:0]      count,
  output logic               eventPulse,
  output logic               thrPulse
);
  logic          sync1;
  logic          sync2;
  logic          lastLevel;
  logic          fired;
  logic          next_lastLevel;
  logic          next_fired;
  logic          next_alarm;
  logic [CW-1:0] next_count;
  logic          effLevel;
  logic          rise;

  always_comb begin
    effLevel       = sync2 ^ invert;
    rise           = effLevel & ~lastLevel;
    next_lastLevel = effLevel;
    next_fired     = fired;
    next_alarm     = alarm;
    next_count     = count;
    eventPulse     = 1'b0;
    thrPulse       = 1'b0;
    if (clearCount) begin
      next_count = '0;
    end
    if (clearCount || rearm) begin
      next_fired = 1'b0;
    end
    if (!enable) begin
      next_alarm = alarm;
    end else if (mode == DIA_LEVEL) begin
      next_alarm = effLevel;
    end else if (rise && !clearCount) begin
      next_count = count + 1'b1;
      eventPulse = 1'b1;
      if (threshold != 16'h0000 && !fired && !rearm &&
          next_count == CW'(threshold)) begin
        next_alarm = 1'b1;
        next_fired = 1'b1;
        thrPulse   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      lastLevel <= 1'b0;
      fired     <= 1'b0;
      alarm     <= 1'b0;
      count     <= '0;
    end else begin
      sync1     <= senseIn;
      sync2     <= sync1;
      lastLevel <= next_lastLevel;
      fired     <= next_fired;
      alarm     <= next_alarm;
      count     <= next_count;
    end
  end
endmodule : dia_channel
`default_nettype wire

// file: rtl/dia_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dia_cfg.svh"
module dia_top
  import dia_pkg::*;
#(
  parameter int NCH = 2,
  parameter int CW  = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [1:0]  sense_input,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic [1:0]       alarmOut,
  output logic             irq
);
  logic [7:0]          ctrl;
  logic [1:0][15:0]    thr;
  logic [3:0]          irqStat;
  logic [3:0]          irqMask;
  logic [7:0]          next_ctrl;
  logic [1:0][15:0]    next_thr;
  logic [3:0]          next_irqStat;
  logic [3:0]          next_irqMask;
  logic [31:0]         next_dat;
  logic                next_ack;
  logic [1:0]          next_alarmOut;
  logic                next_irq;
  logic [1:0]          clrCmd;
  logic [1:0]          rearmCmd;
  logic [1:0]          chAlarm;
  logic [1:0][CW-1:0]  chCount;
  logic [1:0]          evPulse;
  logic [1:0]          thPulse;
  logic                wrStb;
  logic                rdStb;
  logic [31:0]         wmask;

  assign wrStb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rdStb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      dia_channel #(.CW(CW)) u_ch (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .senseIn    (sense_input[g]),
        .enable     (ctrl[g*`DIA_CTRL_STRIDE + `DIA_CTRL_EN]),
        .mode       (dia_mode_t'(ctrl[g*`DIA_CTRL_STRIDE + `DIA_CTRL_MODE])),
        .invert     (ctrl[g*`DIA_CTRL_STRIDE + `DIA_CTRL_INV]),
        .threshold  (thr[g]),
        .clearCount (clrCmd[g]),
        .rearm      (rearmCmd[g]),
        .alarm      (chAlarm[g]),
        .count      (chCount[g]),
        .eventPulse (evPulse[g]),
        .thrPulse   (thPulse[g])
      );
    end
  endgenerate

  always_comb begin
    next_ctrl    = ctrl;
    next_thr     = thr;
    next_irqMask = irqMask;
    next_irqStat = irqStat;
    clrCmd       = 2'b00;
    rearmCmd     = 2'b00;
    next_ack     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat     = 32'h0000_0000;
    if (wrStb) begin
      case (wb_adr_i)
        `DIA_OFS_CTRL: begin
          next_ctrl = (ctrl & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          rearmCmd[0] = next_ctrl[`DIA_CTRL_MODE] != ctrl[`DIA_CTRL_MODE];
          rearmCmd[1] = next_ctrl[`DIA_CTRL_STRIDE + `DIA_CTRL_MODE] !=
                        ctrl[`DIA_CTRL_STRIDE + `DIA_CTRL_MODE];
        end
        `DIA_OFS_THR0: begin
          next_thr[0] = (thr[0] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          rearmCmd[0] = 1'b1;
        end
        `DIA_OFS_THR1: begin
          next_thr[1] = (thr[1] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
          rearmCmd[1] = 1'b1;
        end
        `DIA_OFS_IRQMSK: next_irqMask = (irqMask & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
        `DIA_OFS_CLR:    clrCmd = wb_dat_i[1:0] & wmask[1:0];
        default: begin
        end
      endcase
    end
    if (wrStb && wb_adr_i == `DIA_OFS_IRQST) begin
      next_irqStat = irqStat & ~(wb_dat_i[3:0] & wmask[3:0]);
    end
    next_irqStat = next_irqStat | {thPulse, evPulse};
    if (rdStb) begin
      case (wb_adr_i)
        `DIA_OFS_CTRL:   next_dat = {24'h000000, ctrl};
        `DIA_OFS_THR0:   next_dat = {16'h0000, thr[0]};
        `DIA_OFS_THR1:   next_dat = {16'h0000, thr[1]};
        `DIA_OFS_CNT0:   next_dat = 32'(chCount[0]);
        `DIA_OFS_CNT1:   next_dat = 32'(chCount[1]);
        `DIA_OFS_STAT:   next_dat = {30'h0, chAlarm};
        `DIA_OFS_IRQST:  next_dat = {28'h0000000, irqStat};
        `DIA_OFS_IRQMSK: next_dat = {28'h0000000, irqMask};
        default:         next_dat = 32'h0000_0000;
      endcase
    end
    next_alarmOut = chAlarm;
    next_irq      = |(next_irqStat & next_irqMask);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl     <= `DIA_RST_CTRL;
      thr      <= {`DIA_RST_THR, `DIA_RST_THR};
      irqStat  <= 4'h0;
      irqMask  <= `DIA_RST_MASK;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      alarmOut <= 2'b00;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      thr      <= next_thr;
      irqStat  <= next_irqStat;
      irqMask  <= next_irqMask;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      alarmOut <= next_alarmOut;
      irq      <= next_irq;
    end
  end
endmodule : dia_top
`default_nettype wire

// file: tb/dia_src.sv
`timescale 1ns/100ps
`default_nettype none
module dia_src (
  input  wire logic [1:0] level,
  input  wire logic       clk_sys,
  output logic [1:0]      sense_input
);
  logic [1:0] held = 2'b00;
  always @(posedge clk_sys) begin
    held <= level;
  end
  assign sense_input = held;
endmodule : dia_src
`default_nettype wire

// file: tb/dia_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dia_chk (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic [1:0]  sense_input,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  alarmOut
);
  logic [6:0]  ctrl, next_ctrl;
  logic [15:0] thr1, next_thr1;
  logic        take, lvl0, cnt0, cnt1z;
  assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
  assign lvl0  = ctrl[0] & ~ctrl[1];
  assign cnt0  = ctrl[0] & ctrl[1];
  assign cnt1z = ctrl[4] & ctrl[5] & (thr1 == 16'h0000);
  always_comb begin
    next_ctrl = (take && wb_adr_i == 8'h00) ? wb_dat_i[6:0] : ctrl;
    next_thr1 = (take && wb_adr_i == 8'h08) ? wb_dat_i[15:0] : thr1;
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl <= '0;
      thr1 <= '0;
    end else begin
      ctrl <= next_ctrl;
      thr1 <= next_thr1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  sequence quiet_s;
    (lvl0 && $stable({ctrl[2:0], sense_input[0]}))[*5];
  endsequence
  sequence frozen_s;
    !$past(ctrl[0]) && !$past(ctrl[0], 2);
  endsequence
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  unmapped_rd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C |-> wb_dat_o == 32'h0)
    else $error("unmapped read nonzero");
  level_map_a: assert property (quiet_s |-> alarmOut[0] == (sense_input[0] ^ ctrl[2]))
    else $error("level alarm wrong");
  dis_freeze_a: assert property (frozen_s |-> $stable(alarmOut[0]))
    else $error("disabled alarm moved");
  thr_zero_a: assert property ($past(cnt1z) && $past(cnt1z, 2) && !$past(alarmOut[1]) |-> !alarmOut[1])
    else $error("zero threshold alarm");
  alarm_hold_a: assert property ($past(cnt0) && $past(cnt0, 2) && $past(alarmOut[0]) |-> alarmOut[0])
    else $error("counter alarm dropped");
endmodule : dia_chk
bind dia_top dia_chk i_chk (.clk_sys(clk_sys), .resetn(resetn), .sense_input(sense_input),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .alarmOut(alarmOut));
`default_nettype wire

// file: tb/dia_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module dia_top_test;
  logic        clk_sys = 1'b0, resetn = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, irq;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0, rdDat;
  logic [1:0]  level = 2'b00, sense, alarmOut, s;
  logic [32:0] expQ[$];
  int          errorCnt = 0, numChecks = 0, cycles = 0, i;
  always #12.5 clk_sys = ~clk_sys;
  dia_src i_src (.level(level), .clk_sys(clk_sys), .sense_input(sense));
  dia_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .sense_input(sense), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
    .wb_dat_o(rdDat), .wb_ack_o(wbAck), .alarmOut(alarmOut), .irq(irq));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stopTest();
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stopTest
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbDat <= dat;
    @(posedge clk_sys iff wbAck);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] adr, input logic [32:0] exp);
    expQ.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask : rd
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      level <= 2'b11;
      repeat (4) @(posedge clk_sys);
      level <= 2'b00;
      repeat (4) @(posedge clk_sys);
    end
  endtask : pulse
  // Read monitor with irq seen at the same edge
  always @(posedge clk_sys) begin
    cycles++;
    if (wbAck && !wbWe) begin
      check({irq, rdDat}, expQ.pop_front());
    end
    if (cycles == 5000) begin
      errorCnt++;
      stopTest();
    end
  end
  initial begin
    void'($urandom(32'hE81E158D));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h0C, 33'h0);
    bus(1'b1, 8'h24, 32'hFFFFFFFF);
    rd(8'h24, 33'h0);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b1, 8'h1C, 32'h4);
    bus(1'b1, 8'h00, 32'h33);
    for (i = 1; i <= 3; i++) begin
      pulse(1);
      rd(8'h0C, {i == 3, 32'(i)});
      rd(8'h10, {i == 3, 32'(i)});
      rd(8'h14, {i == 3, 31'h0, i == 3});
    end
    rd(8'h18, {1'b1, 32'h7});
    bus(1'b1, 8'h18, 32'hF);
    pulse(1);
    rd(8'h18, {1'b0, 32'h3});
    rd(8'h0C, {1'b0, 32'h4});
    bus(1'b1, 8'h20, 32'h1);
    rd(8'h0C, 33'h0);
    pulse(3);
    rd(8'h18, {1'b1, 32'h7});
    rd(8'h10, {1'b1, 32'h7});
    bus(1'b1, 8'h1C, 32'h0);
    bus(1'b1, 8'h00, 32'h51);
    for (i = 0; i < 6; i++) begin
      s = 2'($urandom);
      @(posedge clk_sys);
      level <= s;
      repeat (8) @(posedge clk_sys);
      rd(8'h14, {31'h0, ~s[1], s[0]});
    end
    bus(1'b1, 8'h00, 32'h0);
    level <= ~s;
    repeat (8) @(posedge clk_sys);
    rd(8'h14, {31'h0, ~s[1], s[0]});
    stopTest();
  end
endmodule : dia_top_test
`default_nettype wire
